// >>> hdl/mgmt_paging_pkg.sv
package mgmt_paging_pkg;

    // ---------------------------------------------------------------
    // address space
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned HOST_BYTES   = 256;
    localparam int unsigned PAGE_BYTES   = 128;
    localparam int unsigned OFS_W        = 7;
    localparam logic [7:0]  LOWER_LAST   = 8'h7f;
    localparam logic [7:0]  UPPER_FIRST  = 8'h80;
    localparam logic [7:0]  UPPER_LAST   = 8'hff;

    // selection bytes in the lower region
    localparam logic [7:0]  BANK_SEL_ADDR = 8'h7e;
    localparam logic [7:0]  PAGE_SEL_ADDR = 8'h7f;
    localparam logic [7:0]  PAGE_SEL_RST  = 8'h00;
    localparam logic [7:0]  BANK_SEL_RST  = 8'h00;

    // implemented pages
    localparam logic [7:0]  PAGE_ID       = 8'h00;
    localparam logic [7:0]  PAGE_ADV      = 8'h01;
    localparam logic [7:0]  PAGE_THR      = 8'h02;
    localparam logic [7:0]  PAGE_LANE_LO  = 8'h10;
    localparam logic [7:0]  PAGE_LANE_HI  = 8'h1f;
    localparam int unsigned LANE_PAGES    = 16;
    localparam int unsigned LANES_PER_BANK = 8;
    localparam int unsigned NUM_BANKS     = 2;
    localparam int unsigned FIXED_SLOTS   = 3;
    localparam int unsigned NUM_SLOTS     = FIXED_SLOTS + NUM_BANKS * LANE_PAGES;
    localparam int unsigned SLOT_W        = 6;
    localparam int unsigned PMEM_W        = SLOT_W + OFS_W;
    localparam int unsigned PMEM_DEPTH    = NUM_SLOTS * PAGE_BYTES;
    localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

    // synchroniser idle levels: asserted reset, low power
    localparam logic [1:0]  SYNC_RST_VAL  = 2'b00;

    typedef struct packed {
        logic                write;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } host_req_t;

    typedef struct packed {
        logic                we;
        logic [OFS_W-1:0]    addr;
        logic [DATA_W-1:0]   wdata;
    } dev_wr_t;

    typedef enum logic { MODE_FLAT, MODE_PAGED } mem_mode_t;

endpackage

// >>> hdl/module_mgmt_paging_sideband.sv
// What this block does
// - host sees exactly 256 byte addresses
// - lower 00h-7Fh, upper 80h-FFh
// - one 128-byte page mapped into upper
// - lower region reachable whatever page selected
// - bank selects instance of repeated page
// - flat variant: no paging behind upper
// - flags in lower, identification in pages
// - lower region and page 00h always present
// - paged: pages 01h, 02h, 10h, 11h
// - pages 10h-1Fh banked, 8 lanes each
// - extra pages only when paged
// - lowest zone: held in reset, no interrupt
// - middle zone: running, interrupt deasserted
// - interrupt only while out of reset
// - low level means low-power request
// - presence shown by module pull-down
// - lowest zone: low-power state
// - middle zone: high power allowed once out of reset
// - reset active low, interrupt active high
`timescale 1ns/1ps
`default_nettype none

module module_mgmt_paging_sideband (
    input  wire logic                               clock,
    input  wire logic                               rstn,
    // decoded sideband levels from the comparators
    input  wire logic                               module_side_reset_n,
    input  wire logic                               module_lowpower_sense_n,
    // strap: high for a paged module, low for a flat one
    input  wire logic                               paged_strap,
    // interrupt request from the module's own monitors
    input  wire logic                               irq_request,
    // host management access, already deserialised
    input  wire logic                               host_valid,
    input  wire mgmt_paging_pkg::host_req_t         host_req,
    output logic                                    host_ready,
    output logic                                    host_done,
    output logic [mgmt_paging_pkg::DATA_W-1:0]      host_rdata,
    // module-side flag and monitor updates into the lower region
    input  wire mgmt_paging_pkg::dev_wr_t           dev_wr,
    // sideband and status
    output logic                                    irq_drive,
    output logic                                    presence_pulldown_en,
    output logic                                    module_in_reset,
    output logic                                    lowpower_mode,
    output logic                                    high_power_allowed,
    output logic                                    paged_mode,
    output logic [7:0]                              page_sel,
    output logic [7:0]                              bank_sel,
    output logic                                    upper_unmapped
);

    // ---------------------------------------------------------------
    // sideband synchronisers
    // ---------------------------------------------------------------
    // both start at the asserted level so nothing runs before the lines settle
    logic rst_level;
    logic lpw_level;

    level_sync #(
        .RST_VAL   (mgmt_paging_pkg::SYNC_RST_VAL[0])
    ) u_level_sync_rst (
        .clock     (clock),
        .rstn      (rstn),
        .level_in  (module_side_reset_n),
        .level_out (rst_level)
    );

    level_sync #(
        .RST_VAL   (mgmt_paging_pkg::SYNC_RST_VAL[1])
    ) u_level_sync_lpw (
        .clock     (clock),
        .rstn      (rstn),
        .level_in  (module_lowpower_sense_n),
        .level_out (lpw_level)
    );

    logic held_in_reset;
    assign held_in_reset = !rst_level;

    // ---------------------------------------------------------------
    // sideband outputs
    // ---------------------------------------------------------------
    logic irq_ff;
    logic lpw_ff;

    // interrupt drive is dropped the cycle reset is seen, never overlaps it
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            irq_ff <= 1'b0;
        else
            irq_ff <= irq_request && !held_in_reset;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            lpw_ff <= 1'b1;
        else
            lpw_ff <= !lpw_level;
    end

    assign irq_drive            = irq_ff && !held_in_reset;
    assign presence_pulldown_en = 1'b1;
    assign module_in_reset      = held_in_reset;
    assign lowpower_mode        = lpw_ff;
    assign high_power_allowed   = !lpw_ff && !held_in_reset;

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    // caught one edge after release so the flop never loads a port under reset
    logic strap_taken_ff;
    logic paged_ff;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            strap_taken_ff <= 1'b0;
        else
            strap_taken_ff <= 1'b1;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            paged_ff <= 1'b0;
        else if (!strap_taken_ff)
            paged_ff <= paged_strap;
    end

    assign paged_mode = paged_ff;

    // ---------------------------------------------------------------
    // request acceptance
    // ---------------------------------------------------------------
    // module updates own the lower port; host waits while dev_wr.we is high instead of losing data
    logic host_take;
    logic is_upper;
    logic [mgmt_paging_pkg::OFS_W-1:0] ofs;

    assign host_ready = !dev_wr.we && !held_in_reset;
    assign host_take  = host_valid && host_ready;
    assign is_upper   = host_req.addr[mgmt_paging_pkg::ADDR_W-1];
    assign ofs        = host_req.addr[mgmt_paging_pkg::OFS_W-1:0];

    // selection bytes sit in the lower region, so the upper bit never aliases them
    logic host_wr_take;
    logic sel_page_hit;
    logic sel_bank_hit;

    assign host_wr_take = host_take && host_req.write;
    assign sel_page_hit = host_req.addr == mgmt_paging_pkg::PAGE_SEL_ADDR;
    assign sel_bank_hit = host_req.addr == mgmt_paging_pkg::BANK_SEL_ADDR;

    // ---------------------------------------------------------------
    // page and bank selection
    // ---------------------------------------------------------------
    logic [7:0] page_sel_ff;
    logic [7:0] bank_sel_ff;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            page_sel_ff <= mgmt_paging_pkg::PAGE_SEL_RST;
        else if (held_in_reset)
            page_sel_ff <= mgmt_paging_pkg::PAGE_SEL_RST;
        else if (host_wr_take && sel_page_hit)
            page_sel_ff <= host_req.wdata;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            bank_sel_ff <= mgmt_paging_pkg::BANK_SEL_RST;
        else if (held_in_reset)
            bank_sel_ff <= mgmt_paging_pkg::BANK_SEL_RST;
        else if (host_wr_take && sel_bank_hit)
            bank_sel_ff <= host_req.wdata;
    end

    assign page_sel = page_sel_ff;
    assign bank_sel = bank_sel_ff;

    // ---------------------------------------------------------------
    // page slot mapping
    // ---------------------------------------------------------------
    logic                                 slot_ok;
    logic [mgmt_paging_pkg::SLOT_W-1:0]   slot;
    logic [7:0]                           lane_idx;
    logic                                 is_fixed_page;
    logic                                 is_lane_page;
    logic                                 bank_ok;
    logic [mgmt_paging_pkg::SLOT_W-1:0]   lane_base;

    // pages outside this set read as unmapped rather than aliasing a real page
    assign is_fixed_page = page_sel_ff == mgmt_paging_pkg::PAGE_ADV || page_sel_ff == mgmt_paging_pkg::PAGE_THR;
    assign is_lane_page  = page_sel_ff >= mgmt_paging_pkg::PAGE_LANE_LO
                        && page_sel_ff <= mgmt_paging_pkg::PAGE_LANE_HI;
    assign bank_ok       = bank_sel_ff < 8'(mgmt_paging_pkg::NUM_BANKS);
    assign lane_base     = mgmt_paging_pkg::SLOT_W'(mgmt_paging_pkg::FIXED_SLOTS)
                         + mgmt_paging_pkg::SLOT_W'({bank_sel_ff[0], 4'h0});

    always_comb
    begin
        slot_ok  = 1'b0;
        slot     = '0;
        lane_idx = page_sel_ff - mgmt_paging_pkg::PAGE_LANE_LO;
        if (!paged_ff)
        begin
            slot_ok = 1'b1;
        end
        else if (page_sel_ff == mgmt_paging_pkg::PAGE_ID)
        begin
            slot_ok = 1'b1;
        end
        else if (is_fixed_page)
        begin
            slot_ok = 1'b1;
            slot    = mgmt_paging_pkg::SLOT_W'(page_sel_ff);
        end
        else if (is_lane_page && bank_ok)
        begin
            // each bank covers the next group of lanes
            slot_ok = 1'b1;
            slot    = lane_base + mgmt_paging_pkg::SLOT_W'(lane_idx[3:0]);
        end
    end

    assign upper_unmapped = !slot_ok;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0] lower_mem [mgmt_paging_pkg::PAGE_BYTES];
    logic [7:0] page_mem  [mgmt_paging_pkg::PMEM_DEPTH];
    logic [mgmt_paging_pkg::PMEM_W-1:0] paddr;

    assign paddr = {slot, ofs};

    always_ff @(posedge clock)
    begin
        if (dev_wr.we)
            lower_mem[dev_wr.addr] <= dev_wr.wdata;
        else if (host_wr_take && !is_upper)
            lower_mem[ofs] <= host_req.wdata;
    end

    always_ff @(posedge clock)
    begin
        // writes to an unmapped page are dropped, never redirected
        if (host_wr_take && is_upper && slot_ok)
            page_mem[paddr] <= host_req.wdata;
    end

    // ---------------------------------------------------------------
    // read answer
    // ---------------------------------------------------------------
    logic       done_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb
    begin
        if (sel_page_hit)
            nxt_rdata = page_sel_ff;
        else if (sel_bank_hit)
            nxt_rdata = bank_sel_ff;
        else if (!is_upper)
            nxt_rdata = lower_mem[ofs];
        else if (slot_ok)
            nxt_rdata = page_mem[paddr];
        else
            nxt_rdata = mgmt_paging_pkg::UNMAPPED_DATA;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            done_ff <= 1'b0;
        else
            done_ff <= host_take;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= 8'h00;
        else if (host_take && !host_req.write)
            rdata_ff <= nxt_rdata;
    end

    assign host_done  = done_ff;
    assign host_rdata = rdata_ff;

endmodule

// ---------------------------------------------------------------
// two-flop level synchroniser
// ---------------------------------------------------------------
// only the second flop is read outside; the first may go metastable
module level_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic level_in,
    output logic      level_out
);

    logic [1:0] sync_ff;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sync_ff <= {2{RST_VAL}};
        else
            sync_ff <= {sync_ff[0], level_in};
    end

    assign level_out = sync_ff[1];

endmodule

`default_nettype wire

// >>> verif/mgmt_paging_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_paging_monitor (
    input wire logic                       clock,
    input wire logic                       rstn,
    input wire logic                       module_side_reset_n,
    input wire logic                       module_lowpower_sense_n,
    input wire logic                       irq_request,
    input wire logic                       host_valid,
    input wire mgmt_paging_pkg::host_req_t host_req,
    input wire logic                       host_ready,
    input wire logic                       host_done,
    input wire logic [7:0]                 host_rdata,
    input wire mgmt_paging_pkg::dev_wr_t   dev_wr,
    input wire logic                       irq_drive,
    input wire logic                       module_in_reset,
    input wire logic                       lowpower_mode,
    input wire logic [7:0]                 page_sel
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire take = host_valid && host_ready;

    property p_done; take |=> host_done; endproperty
    a_done: assert property (p_done) else $error("no done after take");
    property p_hold; !(take && !host_req.write) |=> $stable(host_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_page; take && host_req.write && host_req.addr == 8'h7f |=> page_sel == $past(host_req.wdata);
    endproperty
    a_page: assert property (p_page) else $error("page select not taken");
    property p_sel_rst; module_in_reset |=> page_sel == 8'h00; endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("page kept in reset");
    property p_rst_in; !module_side_reset_n |-> ##2 module_in_reset; endproperty
    a_rst_in: assert property (p_rst_in) else $error("reset zone missed");
    property p_rst_out; module_side_reset_n [*2] |=> !module_in_reset; endproperty
    a_rst_out: assert property (p_rst_out) else $error("stuck in reset");
    property p_irq; module_in_reset |-> !irq_drive; endproperty
    a_irq: assert property (p_irq) else $error("interrupt during reset");
    property p_irq_off; !irq_request |=> !irq_drive; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without request");
    property p_lp; !module_lowpower_sense_n |-> ##3 lowpower_mode; endproperty
    a_lp: assert property (p_lp) else $error("low power not entered");
    property p_ready; dev_wr.we |-> !host_ready; endproperty
    a_ready: assert property (p_ready) else $error("host not stalled");
    c_page: cover property (take && host_req.write && host_req.addr == 8'h7f);
    c_irq: cover property (irq_drive);
    c_lp: cover property ($fell(lowpower_mode));
endmodule
`default_nettype wire

// >>> verif/host_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
    input  wire logic host_reset_drive_n,
    input  wire logic host_lowpower_drive_n,
    input  wire logic irq_drive,
    input  wire logic presence_pulldown_en,
    output logic      module_side_reset_n,
    output logic      module_lowpower_sense_n,
    output logic      host_int,
    output logic      host_presence_sense_n
);
    // host low pulls the line to the lowest zone over the module
    assign module_side_reset_n = host_reset_drive_n;
    assign host_int = host_reset_drive_n && irq_drive;
    // no pull-down: line floats to the top zone
    assign module_lowpower_sense_n = host_lowpower_drive_n || !presence_pulldown_en;
    assign host_presence_sense_n = !presence_pulldown_en;
endmodule
`default_nettype wire

// >>> verif/module_mgmt_paging_sideband_bench.sv
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_paging_sideband_bench;
    logic clock = 1'b0, rstn = 1'b0, paged_strap = 1'b1, irq_request = 1'b0, host_valid = 1'b0;
    logic host_reset_drive_n = 1'b0, host_lowpower_drive_n = 1'b0;
    logic module_side_reset_n, module_lowpower_sense_n, host_int, host_presence_sense_n;
    logic host_ready, host_done, irq_drive, presence_pulldown_en, module_in_reset, lowpower_mode;
    logic high_power_allowed, paged_mode, upper_unmapped;
    logic [7:0] host_rdata, page_sel, bank_sel;
    mgmt_paging_pkg::host_req_t host_req = '0;
    mgmt_paging_pkg::dev_wr_t   dev_wr = '0;
    logic [7:0]  pages [9] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h1f, 8'h03, 8'h0f, 8'h20};
    logic [31:0] rnd = 32'hfcd2;
    int mismatches = 0, checks_done = 0, cycles = 0, pg = 0, bk = 0, mem[int];
    bit paged_m = 1'b1;

    module_mgmt_paging_sideband u_module_mgmt_paging_sideband (.clock, .rstn, .module_side_reset_n,
        .module_lowpower_sense_n, .paged_strap, .irq_request, .host_valid, .host_req, .host_ready,
        .host_done, .host_rdata, .dev_wr, .irq_drive, .presence_pulldown_en, .module_in_reset,
        .lowpower_mode, .high_power_allowed, .paged_mode, .page_sel, .bank_sel, .upper_unmapped);
    host_board_model u_host_board_model (.host_reset_drive_n, .host_lowpower_drive_n, .irq_drive,
        .presence_pulldown_en, .module_side_reset_n, .module_lowpower_sense_n, .host_int,
        .host_presence_sense_n);

    always #20 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // model slot of a host address, -1 when nothing is mapped there
    function automatic int where(input int a);
        if (a < 'h80) return a;
        if (!paged_m || pg < 3) return 'h100 + pg * 128 * paged_m + a;
        if (pg >= 'h10 && pg <= 'h1f && bk < 2) return 'h1000 + (bk * 32 + pg) * 128 + a;
        return -1;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // dv >= 0 adds a module write in the same cycle, which must win
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input int dv);
        int n, k, e;
        n = 0;
        @(posedge clock);
        host_valid <= 1'b1;
        host_req <= '{wr, a, d};
        if (dv >= 0) dev_wr <= '{1'b1, a[6:0], dv[7:0]};
        @(negedge clock);
        while (host_ready !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            dev_wr.we <= 1'b0;
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        host_valid <= 1'b0;
        dev_wr.we <= 1'b0;
        @(negedge clock);
        if (dv >= 0) mem[a] = dv;
        k = where(a);
        check({7'h00, host_done}, 8'h01);
        if (wr && a == 8'h7e) bk = d;
        else if (wr && a == 8'h7f) pg = d;
        else if (wr && k >= 0) mem[k] = d;
        else if (!wr)
        begin
            e = a == 8'h7e ? bk : a == 8'h7f ? pg : k < 0 ? 0 : mem.exists(k) ? mem[k] : -1;
            if (e >= 0) check(host_rdata, e[7:0]);
        end
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        host_reset_drive_n <= 1'b1;
        repeat (3) @(negedge clock);
        check({7'h00, host_presence_sense_n}, 8'h00);
        check({7'h00, lowpower_mode}, 8'h01);
        @(posedge clock) host_lowpower_drive_n <= 1'b1;
        repeat (4) @(negedge clock);
        check({7'h00, high_power_allowed}, 8'h01);
        for (int p = 0; p < 2; p++)
            foreach (pages[i])
                for (int b = 0; b < 3; b++)
                begin
                    rnd = lfsr(rnd);
                    access(1'b1, 8'h7e, b[7:0], -1);
                    access(1'b1, 8'h7f, pages[i], -1);
                    check(page_sel, pg[7:0]);
                    check({7'h00, upper_unmapped}, {7'h00, where('h80) < 0});
                    if (p == 0) access(1'b1, 8'(8'h80 + i * 13), rnd[7:0], -1);
                    access(1'b0, 8'(8'h80 + i * 13), 8'h00, -1);
                    access(1'b0, 8'h7e, 8'h00, -1);
                    access(1'b0, {2'b00, rnd[13:8]}, 8'h00, int'(rnd[23:16]));
                end
        @(posedge clock) irq_request <= 1'b1;
        repeat (4) @(negedge clock);
        check({7'h00, host_int}, 8'h01);
        @(posedge clock) host_reset_drive_n <= 1'b0;
        repeat (4) @(negedge clock);
        check({7'h00, host_int}, 8'h00);
        check({7'h00, module_in_reset}, 8'h01);
        check(page_sel, 8'h00);
        @(posedge clock);
        rstn <= 1'b0;
        paged_strap <= 1'b0;
        host_reset_drive_n <= 1'b1;
        irq_request <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(negedge clock);
        paged_m = 1'b0;
        pg = 0;
        bk = 0;
        mem.delete();
        check({7'h00, module_in_reset}, 8'h00);
        check({7'h00, paged_mode}, 8'h00);
        access(1'b1, 8'h7f, 8'h20, -1);
        check({7'h00, upper_unmapped}, 8'h00);
        access(1'b1, 8'hc4, rnd[31:24], -1);
        access(1'b0, 8'hc4, 8'h00, -1);
        give_verdict;
    end
endmodule

bind module_mgmt_paging_sideband mgmt_paging_monitor u_mgmt_paging_monitor (.clock, .rstn,
    .module_side_reset_n, .module_lowpower_sense_n, .irq_request, .host_valid, .host_req, .host_ready,
    .host_done, .host_rdata, .dev_wr, .irq_drive, .module_in_reset, .lowpower_mode, .page_sel);
`default_nettype wire
